// [ias_indirect_addr_stack_unit.sv]
// top of the indirect addressing and return stack unit
// assumes the cpu datapath issues one operation per cycle on the same clock
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - with fault reset enabled, push past sixteen or pop below one resets device.
// - fault reset sets overflow flag for push, underflow flag for pop.
// - each return with a non-empty stack pops stack and loads popped address into program counter.
// - interrupt entry pushes return address exactly like a call.
// - window registers hold nothing; access goes to pointer address.
// - pointer naming a window register reads zero.
// - pointer naming a window register discards writes; flags may change.
// - pointer is high byte concatenated with low byte, sixteen bits.
// - pointer space splits into traditional, linear and flash regions.
// - pointer 0x000 to 0xFFF maps to absolute register addresses.
// - 0x2000 to 0x29AF views the ram blocks of banks 0 to 30 contiguously, no common bytes.
// - unimplemented linear locations read zero.
// - pointer top bit set addresses flash, low byte only, no writes.
// - flash access through window takes one extra cycle.
module ias_indirect_addr_stack_unit (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic call_req,
	input wire logic irq_entry,
	input wire logic ret_req,
	input wire logic [14:0] return_addr,
	input wire logic [7:0] pointer_high_byte,
	input wire logic [7:0] pointer_low_byte,
	input wire logic ind_rd,
	input wire logic ind_wr,
	input wire logic [7:0] ind_wdata,
	input wire logic [7:0] ram_rdata,
	input wire logic [7:0] flash_rdata,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic [14:0] pc_load_addr,
	output logic pc_load,
	output logic [11:0] ram_addr,
	output logic ram_we,
	output logic [7:0] ram_wdata,
	output logic [14:0] flash_addr,
	output logic [7:0] ind_rdata,
	output logic ind_valid,
	output logic ind_stall,
	output logic device_reset,
	output logic stack_over_flag,
	output logic stack_under_flag,
	output logic irq
);
	// ****************************************
	// stack
	// ****************************************
	logic push;
	logic [14:0] top;
	logic ovf;
	logic unf;
	logic [4:0] level;
	logic fault_en_q;
	logic [ias_pkg::ST_W-1:0] st_q;
	logic [ias_pkg::ST_W-1:0] mask_q;
	logic st_rd_clr;
	assign push = call_req || irq_entry;
	ias_stack u_stack (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.push(push),
		.pop(ret_req),
		.push_addr(return_addr),
		.top_addr(top),
		.ovf(ovf),
		.unf(unf),
		.level(level)
	);
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc_load <= 1'b0;
			pc_load_addr <= '0;
		end else begin
			pc_load <= ret_req && !unf;
			pc_load_addr <= top;
		end
	end
	// power control status flags survive the reset they cause
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			device_reset <= 1'b0;
			stack_over_flag <= 1'b0;
			stack_under_flag <= 1'b0;
		end else begin
			device_reset <= fault_en_q && (ovf || unf);
			if (fault_en_q && ovf) begin
				stack_over_flag <= 1'b1;
			end
			if (fault_en_q && unf) begin
				stack_under_flag <= 1'b1;
			end
		end
	end
	// ****************************************
	// indirect access
	// ****************************************
	ias_mem_if mi ();
	assign mi.ptr = {pointer_high_byte, pointer_low_byte};
	ias_ptr_decode u_dec (
		.m(mi)
	);
	logic flash_wait_q;
	logic is_flash;
	logic rd_zero;
	assign is_flash = mi.region == ias_pkg::IAS_REG_FLASH;
	assign rd_zero = mi.window_hit || mi.unimpl;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			flash_wait_q <= 1'b0;
		end else if (ind_rd && is_flash) begin
			flash_wait_q <= !flash_wait_q;
		end else begin
			flash_wait_q <= 1'b0;
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ram_addr <= '0;
			ram_we <= 1'b0;
			ram_wdata <= ias_pkg::ZERO_BYTE;
			flash_addr <= '0;
		end else begin
			ram_addr <= mi.phys_addr;
			flash_addr <= mi.flash_addr;
			ram_wdata <= ind_wdata;
			// no writes to flash, window self-reference or holes
			ram_we <= ind_wr && !rd_zero && !is_flash;
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ind_rdata <= ias_pkg::ZERO_BYTE;
			ind_valid <= 1'b0;
			ind_stall <= 1'b0;
		end else begin
			ind_stall <= ind_rd && is_flash && !flash_wait_q;
			ind_valid <= ind_rd && (!is_flash || flash_wait_q);
			if (rd_zero) begin
				ind_rdata <= ias_pkg::ZERO_BYTE;
			end else if (is_flash) begin
				ind_rdata <= flash_rdata;
			end else begin
				ind_rdata <= ram_rdata;
			end
		end
	end
	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic aw_q;
	logic w_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	assign wr_go = aw_q && w_q && !s_axi_bvalid;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ias_pkg::RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			// readies registered: drop with the accept, return with the response
			s_axi_awready <= wr_go || (!aw_q && !(s_axi_awvalid && s_axi_awready));
			s_axi_wready <= wr_go || (!w_q && !(s_axi_wvalid && s_axi_wready));
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == ias_pkg::REG_CTRL || awaddr_q == ias_pkg::REG_MASK)
					? ias_pkg::RESP_OK : ias_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_en_q <= 1'b0;
			mask_q <= '0;
		end else if (wr_go && wstrb_q[0]) begin
			if (awaddr_q == ias_pkg::REG_CTRL) begin
				fault_en_q <= wdata_q[ias_pkg::CTRL_SFRE];
			end
			if (awaddr_q == ias_pkg::REG_MASK) begin
				mask_q <= wdata_q[ias_pkg::ST_W-1:0];
			end
		end
	end
	// read port registered: arready only while idle
	assign st_rd_clr = s_axi_arvalid && s_axi_arready && s_axi_araddr == ias_pkg::REG_STATUS;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= ias_pkg::RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rresp <= ias_pkg::RESP_OK;
			case (s_axi_araddr)
				ias_pkg::REG_CTRL: s_axi_rdata <= {31'h0, fault_en_q};
				ias_pkg::REG_STATUS: s_axi_rdata <= {30'h0, st_q};
				ias_pkg::REG_MASK: s_axi_rdata <= {30'h0, mask_q};
				ias_pkg::REG_DEPTH: s_axi_rdata <= {27'h0, level};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= ias_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end
	// ****************************************
	// interrupt status, read clears, set wins
	// ****************************************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= (st_rd_clr ? '0 : st_q) | {unf, ovf};
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((st_rd_clr ? '0 : st_q) | {unf, ovf}) & mask_q);
		end
	end
endmodule : ias_indirect_addr_stack_unit
`default_nettype wire

// [ias_pkg.sv]
// package for the indirect address and stack unit
// assumes a single core clock domain driven by the cpu datapath
package ias_pkg;
	// ****************************************
	// stack geometry
	// ****************************************
	localparam int STACK_DEPTH = 16;
	localparam int PC_W = 15;
	localparam int PTR_W = 16;
	localparam int DATA_W = 8;
	// ****************************************
	// pointer address map
	// ****************************************
	localparam logic [15:0] TRAD_LAST = 16'h0FFF;
	localparam logic [15:0] LIN_FIRST = 16'h2000;
	localparam logic [15:0] LIN_LAST = 16'h29AF;
	localparam logic [6:0] LIN_BLOCK = 7'h50;
	localparam logic [6:0] RAM_BASE = 7'h20;
	localparam logic [11:0] WIN0_ADDR = 12'h000;
	localparam logic [11:0] WIN1_ADDR = 12'h001;
	localparam logic [6:0] BANK_MASK = 7'h7F;
	localparam int FLASH_BIT = 15;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// ****************************************
	// axi4-lite map (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_DEPTH = 8'h0C;
	localparam int CTRL_SFRE = 0;
	localparam int ST_OVF = 0;
	localparam int ST_UNF = 1;
	localparam int ST_W = 2;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {IAS_REG_TRAD, IAS_REG_LIN, IAS_REG_FLASH, IAS_REG_NONE} ias_region_t;
	typedef enum {IAS_MA_IDLE, IAS_MA_WAIT, IAS_MA_DONE} ias_mstate_t;
endpackage : ias_pkg

// [ias_mem_if.sv]
// interface between the top and the pointer decoder
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface ias_mem_if;
	logic [15:0] ptr;
	ias_pkg::ias_region_t region;
	logic [11:0] phys_addr;
	logic [14:0] flash_addr;
	logic window_hit;
	logic unimpl;
	modport decoder (input ptr, output region, output phys_addr, output flash_addr,
		output window_hit, output unimpl);
	modport user (output ptr, input region, input phys_addr, input flash_addr,
		input window_hit, input unimpl);
endinterface : ias_mem_if
`default_nettype wire

// [ias_ptr_decode.sv]
// pointer region decoder, purely combinational
// assumes pointer comes from same-clock registers
`timescale 1ns/1ps
`default_nettype none
module ias_ptr_decode (
	ias_mem_if.decoder m
);
	logic [15:0] lin_off;
	logic [6:0] lin_bank;
	logic [6:0] lin_idx;
	always_comb begin
		lin_off = m.ptr - ias_pkg::LIN_FIRST;
		lin_bank = 7'(lin_off / 16'(ias_pkg::LIN_BLOCK));
		lin_idx = 7'(lin_off % 16'(ias_pkg::LIN_BLOCK));
		m.region = ias_pkg::IAS_REG_NONE;
		m.phys_addr = 12'h000;
		m.flash_addr = m.ptr[14:0];
		m.unimpl = 1'b0;
		if (m.ptr[ias_pkg::FLASH_BIT]) begin
			m.region = ias_pkg::IAS_REG_FLASH;
		end else if (m.ptr <= ias_pkg::TRAD_LAST) begin
			m.region = ias_pkg::IAS_REG_TRAD;
			m.phys_addr = m.ptr[11:0];
		end else if (m.ptr >= ias_pkg::LIN_FIRST && m.ptr <= ias_pkg::LIN_LAST) begin
			// common bytes skipped: each bank contributes only its ram block
			m.region = ias_pkg::IAS_REG_LIN;
			m.phys_addr = {lin_bank[4:0], 7'(ias_pkg::RAM_BASE + lin_idx)};
		end else begin
			m.unimpl = 1'b1;
		end
		// window check on the final physical address, both regions
		m.window_hit = (m.region == ias_pkg::IAS_REG_TRAD || m.region == ias_pkg::IAS_REG_LIN)
			&& ({5'h00, m.phys_addr[6:0]} == ias_pkg::WIN0_ADDR
			|| {5'h00, m.phys_addr[6:0]} == ias_pkg::WIN1_ADDR);
	end
endmodule : ias_ptr_decode
`default_nettype wire

// [ias_stack.sv]
// sixteen-level return address stack
// assumes at most one of push or pop per cycle
`timescale 1ns/1ps
`default_nettype none
module ias_stack #(
	parameter int DEPTH = ias_pkg::STACK_DEPTH,
	parameter int AW = ias_pkg::PC_W
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic push,
	input wire logic pop,
	input wire logic [AW-1:0] push_addr,
	output logic [AW-1:0] top_addr,
	output logic ovf,
	output logic unf,
	output logic [4:0] level
);
	logic [AW-1:0] mem [DEPTH];
	logic [4:0] level_q;
	assign level = level_q;
	assign top_addr = (level_q == 5'h00) ? '0 : mem[4'(level_q - 5'h01)];
	assign ovf = push && level_q == 5'(DEPTH);
	assign unf = pop && level_q == 5'h00;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			level_q <= 5'h00;
		end else if (push && !ovf) begin
			level_q <= level_q + 5'h01;
		end else if (pop && !unf) begin
			level_q <= level_q - 5'h01;
		end
	end
	always_ff @(posedge core_clk) begin
		if (push && !ovf) begin
			mem[level_q[3:0]] <= push_addr;
		end
	end
endmodule : ias_stack
`default_nettype wire

// [ias_properties.sv]
// checker for the indirect address and stack unit top
// assumes one core clock and bind by port name
`timescale 1ns/1ps
`default_nettype none
module ias_props (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic call_req,
	input wire logic irq_entry,
	input wire logic ret_req,
	input wire logic [14:0] return_addr,
	input wire logic [7:0] pointer_high_byte,
	input wire logic [7:0] pointer_low_byte,
	input wire logic ind_rd,
	input wire logic ind_wr,
	input wire logic [7:0] ind_wdata,
	input wire logic [7:0] ram_rdata,
	input wire logic [7:0] flash_rdata,
	input wire logic [14:0] pc_load_addr,
	input wire logic pc_load,
	input wire logic [11:0] ram_addr,
	input wire logic ram_we,
	input wire logic [7:0] ram_wdata,
	input wire logic [14:0] flash_addr,
	input wire logic [7:0] ind_rdata,
	input wire logic ind_valid,
	input wire logic ind_stall,
	input wire logic device_reset,
	input wire logic stack_over_flag
);
	// ****
	// properties
	// ****
	logic [15:0] p;
	logic trad, win, fl;
	assign p = {pointer_high_byte, pointer_low_byte};
	assign trad = p[15:12] == 4'h0;
	assign win = trad && p[6:1] == 6'h00;
	assign fl = p[15];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_push; (call_req || irq_entry) && !ret_req; endsequence
	sequence s_pop_ok; ret_req && !call_req && !irq_entry && !stack_over_flag; endsequence
	// stall flag excludes the held second cycle of the same request
	sequence s_flash_req; ind_rd && fl && !ind_stall; endsequence
	sequence s_flash_ans;
		ind_stall && flash_addr == p[14:0] ##1 ind_valid && ind_rdata == $past(flash_rdata);
	endsequence
	property p_ret_load; pc_load |-> $past(ret_req); endproperty
	property p_call_ret;
		s_push ##1 s_pop_ok |=> pc_load && pc_load_addr == $past(return_addr, 2);
	endproperty
	property p_ovf_cause; $rose(stack_over_flag) |-> $past(call_req || irq_entry); endproperty
	property p_rst_cause; device_reset |-> $past(call_req || irq_entry || ret_req); endproperty
	property p_wr_trad;
		ind_wr && trad && !win |=> ram_we && {4'h0, ram_addr} == $past(p)
			&& ram_wdata == $past(ind_wdata);
	endproperty
	property p_wr_drop; ind_wr && (win || fl) |=> !ram_we; endproperty
	property p_rd_ram;
		ind_rd && trad && !win |=> ind_valid && ind_rdata == $past(ram_rdata);
	endproperty
	property p_rd_zero;
		ind_rd && (win || p[15:12] == 4'h1 || (p > 16'h29AF && !fl))
			|=> ind_valid && ind_rdata == 8'h00;
	endproperty
	property p_rd_flash; s_flash_req |=> s_flash_ans; endproperty
	a_ret_load: assert property (p_ret_load) else $error("load without return");
	a_call_ret: assert property (p_call_ret) else $error("wrong return address");
	a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without push");
	a_rst_cause: assert property (p_rst_cause) else $error("stray reset");
	a_wr_trad: assert property (p_wr_trad) else $error("bad data write");
	a_wr_drop: assert property (p_wr_drop) else $error("write not dropped");
	a_rd_ram: assert property (p_rd_ram) else $error("bad data read");
	a_rd_zero: assert property (p_rd_zero) else $error("read not zero");
	a_rd_flash: assert property (p_rd_flash) else $error("bad flash read");
endmodule : ias_props
bind ias_indirect_addr_stack_unit ias_props u_props (.*);
`default_nettype wire

// [ias_indirect_addr_stack_unit_tb_top.sv]
// self-checking bench for the indirect address and stack unit
// assumes the checker file is compiled with it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin logic [63:0] ev_m; ev_m = (e); check_count++; \
	if ((a) !== ev_m) begin n_errors++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, ev_m); end end
module ias_indirect_addr_stack_unit_tb_top;
	logic core_clk = 0, sys_rst = 1, call_req = 0, irq_entry = 0, ret_req = 0;
	logic ind_rd = 0, ind_wr = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, pc_load, ram_we, ind_valid, ind_stall, device_reset;
	logic stack_over_flag, stack_under_flag, irq;
	logic [14:0] return_addr = 0, pc_load_addr, flash_addr;
	logic [7:0] pointer_high_byte = 0, pointer_low_byte = 0, ind_wdata = 0, ram_rdata = 0;
	logic [7:0] flash_rdata = 0, s_axi_awaddr = 0, s_axi_araddr = 0, ram_wdata, ind_rdata;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [11:0] ram_addr;
	logic [31:0] exp_q[$];
	logic [14:0] stk[17];
	// kind in bits 29:28 (flash, ram), expected ram address, pointer
	logic [31:0] tbl[9] = '{32'h0000_0000, 32'h0000_0081, 32'h1123_0123, 32'h0000_1000,
		32'h1020_2000, 32'h10A0_2050, 32'h1F6F_29AF, 32'h0000_29B0, 32'h2000_8000};
	int n_errors = 0, check_count = 0, n_rst = 0, seed = 83657, i;
	ias_indirect_addr_stack_unit uut (.*);
	always #10 core_clk = ~core_clk;
	// ****
	// result monitor
	// ****
	always @(posedge core_clk) begin
		if (device_reset) n_rst++;
		if (ind_valid) `CHK(ind_rdata, exp_q.pop_front())
		if (pc_load) `CHK(pc_load_addr, exp_q.pop_front())
		if (s_axi_rvalid && s_axi_rready) `CHK(s_axi_rdata, exp_q.pop_front())
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	// ****
	// drivers
	// ****
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, (a == ias_pkg::REG_CTRL || a == ias_pkg::REG_MASK) ? ias_pkg::RESP_OK : ias_pkg::RESP_SLVERR)
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back(d);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rresp, r)
	endtask : rd
	task automatic ind(input logic [31:0] t, input logic w);
		logic [15:0] p;
		logic [7:0] d, e;
		p = t[15:0];
		if (t[29]) p[14:0] = 15'($random(seed));
		d = 8'($random(seed));
		e = t[28] ? d + 8'h5A : (t[29] ? ~d : 8'h00);
		if (!w) exp_q.push_back(e);
		@(posedge core_clk);
		{pointer_high_byte, pointer_low_byte} <= p;
		ind_wr <= w;
		ind_rd <= !w;
		ind_wdata <= d;
		ram_rdata <= d + 8'h5A;
		flash_rdata <= ~d;
		@(posedge core_clk);
		// flash reads keep the request up through the stall cycle
		if (!w && t[29]) @(posedge core_clk);
		ind_rd <= 1'b0;
		ind_wr <= 1'b0;
		#1;
		if (w) `CHK(ram_we, t[28])
		if (w && t[28]) `CHK({ram_addr, ram_wdata}, {t[27:16], d})
		repeat (2) @(posedge core_clk);
	endtask : ind
	initial begin
		#400000;
		n_errors++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 4; i++) rd(8'(4 * i), 32'h0, ias_pkg::RESP_OK);
		rd(8'h10, 32'h0, ias_pkg::RESP_SLVERR);
		wr(ias_pkg::REG_DEPTH, 32'h5);
		rd(ias_pkg::REG_DEPTH, 32'h0, ias_pkg::RESP_OK);
		wr(ias_pkg::REG_CTRL, 32'h1);
		rd(ias_pkg::REG_CTRL, 32'h1, ias_pkg::RESP_OK);
		wr(ias_pkg::REG_MASK, 32'h3);
		$display("done registers");
		stk[0] = 15'($random(seed));
		exp_q.push_back(stk[0]);
		@(posedge core_clk);
		call_req <= 1'b1;
		return_addr <= stk[0];
		@(posedge core_clk);
		call_req <= 1'b0;
		ret_req <= 1'b1;
		@(posedge core_clk);
		ret_req <= 1'b0;
		for (i = 0; i < 17; i++) begin
			stk[i] = 15'($random(seed));
			@(posedge core_clk);
			call_req <= !i[0];
			irq_entry <= i[0];
			return_addr <= stk[i];
		end
		@(posedge core_clk);
		call_req <= 1'b0;
		irq_entry <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 `CHK({stack_over_flag, irq, n_rst}, {2'h3, 32'd1})
		rd(ias_pkg::REG_DEPTH, 32'd16, ias_pkg::RESP_OK);
		rd(ias_pkg::REG_STATUS, 32'h1, ias_pkg::RESP_OK);
		rd(ias_pkg::REG_STATUS, 32'h0, ias_pkg::RESP_OK);
		#1 `CHK(irq, 1'b0)
		wr(ias_pkg::REG_MASK, 32'h0);
		// last pop runs below the first level
		for (i = 15; i >= -1; i--) begin
			if (i >= 0) exp_q.push_back(stk[i]);
			@(posedge core_clk);
			ret_req <= 1'b1;
		end
		@(posedge core_clk);
		ret_req <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 `CHK({stack_under_flag, irq, n_rst}, {2'h2, 32'd2})
		wr(ias_pkg::REG_MASK, 32'h2);
		repeat (2) @(posedge core_clk);
		#1 `CHK(irq, 1'b1)
		rd(ias_pkg::REG_STATUS, 32'h2, ias_pkg::RESP_OK);
		wr(ias_pkg::REG_CTRL, 32'h0);
		@(posedge core_clk);
		ret_req <= 1'b1;
		@(posedge core_clk);
		ret_req <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 `CHK(n_rst, 2)
		$display("done stack");
		for (i = 0; i < 9; i++) begin
			ind(tbl[i], 1'b1);
			ind(tbl[i], 1'b0);
		end
		$display("done indirect");
		repeat (4) @(posedge core_clk);
		summarize();
	end
endmodule : ias_indirect_addr_stack_unit_tb_top
`default_nettype wire
